// ### src/power_status_and_irq_mask_regs.v
/*
 * Register bank: live rail status, voltage monitor status, top-level interrupt flags and mask.
 * Assumes a serial control interface front end on ref_clk_in that hands over decoded byte
 * accesses, analog status levels that are asynchronous, and event pulses from logic on ref_clk_in.
 */
//
// Overview of operation
// - Step-down enable states at bits 7, 3
// - Step-down live output valid at bits 6, 2
// - Step-down live current limit at bits 4, 0
// - Step-up enable state at bit 3
// - Step-up live output valid at bit 2
// - Step-up live current limit at bit 0
// - Monitor inputs live valid at bits 4, 2
// - Analog supply live valid at bit 0
// - Mask bit 7 blocks load measurement interrupt
// - Mask bit 3 blocks sync clock interrupt
// - Mask bit 1 blocks thermal warning interrupt
// - Thermal mask leaves live status untouched
// - Mask power-up default loaded from OTP
// - Flags latch on event, write one clears
// - Live thermal warning follows die temperature
`timescale 1ns/1ps
`include "power_status_regs_defs.vh"

module power_status_and_irq_mask_regs
(
    input  wire                 ref_clk_in,
    input  wire                 nrst_in,
    input  wire [`ADDR_W-1:0]   reg_addr_in,
    input  wire                 reg_wr_in,
    input  wire [`DATA_W-1:0]   reg_wdata_in,
    input  wire                 reg_rd_in,
    output reg  [`DATA_W-1:0]   reg_rdata_out,
    output reg                  reg_rvalid_out,
    input  wire                 first_stepdown_enabled_in,
    input  wire                 first_stepdown_output_valid_in,
    input  wire                 first_stepdown_at_current_limit_in,
    input  wire                 second_stepdown_enabled_in,
    input  wire                 second_stepdown_output_valid_in,
    input  wire                 second_stepdown_at_current_limit_in,
    input  wire                 stepup_enabled_in,
    input  wire                 stepup_output_valid_in,
    input  wire                 stepup_at_current_limit_in,
    input  wire                 monitor_one_valid_in,
    input  wire                 monitor_two_valid_in,
    input  wire                 analog_supply_valid_in,
    input  wire                 thermal_warning_live_in,
    input  wire                 load_meas_ready_event_in,
    input  wire                 sync_clk_event_in,
    input  wire [`DATA_W-1:0]   otp_mask_default_in,
    output reg                  irq_out
);

    localparam NUM_LIVE = 13;

    // Live level index into the synchroniser vector
    localparam L_SD1_EN = 0;
    localparam L_SD1_PG = 1;
    localparam L_SD1_IL = 2;
    localparam L_SD2_EN = 3;
    localparam L_SD2_PG = 4;
    localparam L_SD2_IL = 5;
    localparam L_SU_EN  = 6;
    localparam L_SU_PG  = 7;
    localparam L_SU_IL  = 8;
    localparam L_MON1   = 9;
    localparam L_MON2   = 10;
    localparam L_ANA    = 11;
    localparam L_TWARN  = 12;

    reg  [NUM_LIVE-1:0] meta_ff;
    reg  [NUM_LIVE-1:0] live_ff;
    reg                 twarn_prev_ff;
    reg  [`DATA_W-1:0]  mask_ff;
    reg  [`DATA_W-1:0]  nxt_mask;
    reg                 mask_loaded_ff;
    reg  [`DATA_W-1:0]  flags_ff;
    reg  [`DATA_W-1:0]  nxt_flags;
    reg  [`DATA_W-1:0]  set_vec;
    reg  [`DATA_W-1:0]  clr_vec;
    reg  [`DATA_W-1:0]  step_down_word;
    reg  [`DATA_W-1:0]  step_up_word;
    reg  [`DATA_W-1:0]  monitor_word;
    reg  [`DATA_W-1:0]  top_live_word;
    reg  [`DATA_W-1:0]  rd_mux;

    wire [NUM_LIVE-1:0] raw_levels;

    // One shared write decode, so the flag clear and the mask write cannot drift apart
    function wr_hit;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] target;
        input               strobe;
    begin
        wr_hit = strobe & (addr == target);
    end
    endfunction

    // Analog comparators are asynchronous; two flops before anything looks at them
    // Status reads lag a pin change by up to three edges; the levels are slow, so that is harmless
    assign raw_levels = {thermal_warning_live_in, analog_supply_valid_in, monitor_two_valid_in,
                         monitor_one_valid_in, stepup_at_current_limit_in, stepup_output_valid_in,
                         stepup_enabled_in, second_stepdown_at_current_limit_in,
                         second_stepdown_output_valid_in, second_stepdown_enabled_in,
                         first_stepdown_at_current_limit_in, first_stepdown_output_valid_in,
                         first_stepdown_enabled_in};

    always @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_ff       <= {NUM_LIVE{1'b0}};
            live_ff       <= {NUM_LIVE{1'b0}};
            twarn_prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff       <= raw_levels;
            live_ff       <= meta_ff;
            twarn_prev_ff <= live_ff[L_TWARN];
        end
    end

    // Status words are assembled straight from the live levels, so they are never latched
    always @*
    begin
        step_down_word = `RST_STATUS;
        step_down_word[`BIT_SD2_ENABLED] = live_ff[L_SD2_EN];
        step_down_word[`BIT_SD1_ENABLED] = live_ff[L_SD1_EN];
        step_down_word[`BIT_SD2_VALID]   = live_ff[L_SD2_PG];
        step_down_word[`BIT_SD1_VALID]   = live_ff[L_SD1_PG];
        step_down_word[`BIT_SD2_ILIM]    = live_ff[L_SD2_IL];
        step_down_word[`BIT_SD1_ILIM]    = live_ff[L_SD1_IL];

        step_up_word = `RST_STATUS;
        step_up_word[`BIT_SU_ENABLED]    = live_ff[L_SU_EN];
        step_up_word[`BIT_SU_VALID]      = live_ff[L_SU_PG];
        step_up_word[`BIT_SU_ILIM]       = live_ff[L_SU_IL];

        monitor_word = `RST_STATUS;
        monitor_word[`BIT_MON_TWO_VALID] = live_ff[L_MON2];
        monitor_word[`BIT_MON_ONE_VALID] = live_ff[L_MON1];
        monitor_word[`BIT_ANALOG_VALID]  = live_ff[L_ANA];

        // The mask never enters this path, so the live bit ignores it
        top_live_word = `RST_STATUS;
        top_live_word[`BIT_THERMAL_WARN] = live_ff[L_TWARN];
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always @*
    begin
        set_vec = `RST_FLAGS;
        // Event pulses come from logic on this clock, so they are taken without synchronising
        set_vec[`BIT_LOAD_MEAS]    = load_meas_ready_event_in;
        set_vec[`BIT_SYNC_CLK]     = sync_clk_event_in;
        // A warning that stays high does not set the flag again until it has dropped
        set_vec[`BIT_THERMAL_WARN] = live_ff[L_TWARN] & ~twarn_prev_ff;
        clr_vec = `RST_FLAGS;
        if (wr_hit(reg_addr_in, `OFS_TOP_INT_FLAGS, reg_wr_in))
            clr_vec = reg_wdata_in;
        nxt_flags = (flags_ff & ~clr_vec) | set_vec;
    end

    // OTP default is taken on the first edge after reset release, never by the reset itself
    always @*
    begin
        nxt_mask = mask_ff;
        // A mask write in that first cycle is dropped; the host must wait one more edge
        if (!mask_loaded_ff)
            nxt_mask = otp_mask_default_in;
        else if (wr_hit(reg_addr_in, `OFS_TOP_MASK_ONE, reg_wr_in))
            nxt_mask = reg_wdata_in;
    end

    // Status offsets have no write path at all
    // Unmapped offsets read zero, so a host probing the map never sees stale data
    always @*
    begin
        case (reg_addr_in)
            `OFS_STEP_DOWN_STATUS: rd_mux = step_down_word;
            `OFS_STEP_UP_STATUS:   rd_mux = step_up_word;
            `OFS_MONITOR_STATUS:   rd_mux = monitor_word;
            `OFS_TOP_LIVE_STATUS:  rd_mux = top_live_word;
            `OFS_TOP_MASK_ONE:     rd_mux = mask_ff;
            `OFS_TOP_INT_FLAGS:    rd_mux = flags_ff;
            default:               rd_mux = `RST_STATUS;
        endcase
    end

    always @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mask_ff        <= `RST_MASK;
            mask_loaded_ff <= 1'b0;
            flags_ff       <= `RST_FLAGS;
            reg_rdata_out  <= `RST_STATUS;
            reg_rvalid_out <= 1'b0;
            irq_out        <= 1'b0;
        end
        else
        begin
            mask_ff        <= nxt_mask;
            mask_loaded_ff <= 1'b1;
            flags_ff       <= nxt_flags;
            reg_rvalid_out <= reg_rd_in;
            // Read data stands until the next read, so a slow host may fetch it late
            if (reg_rd_in)
                reg_rdata_out <= rd_mux;
            // Each mask bit gates only its own source; the flags keep latching underneath
            // Registered so the pin never glitches while flags and mask update
            irq_out <= (flags_ff[`BIT_LOAD_MEAS]    & ~mask_ff[`BIT_LOAD_MEAS])
                     | (flags_ff[`BIT_SYNC_CLK]     & ~mask_ff[`BIT_SYNC_CLK])
                     | (flags_ff[`BIT_THERMAL_WARN] & ~mask_ff[`BIT_THERMAL_WARN]);
        end
    end

endmodule // power_status_and_irq_mask_regs

// ### pkg/power_status_regs_defs.vh
/*
 * Register offsets, field positions and reset values of the power status and interrupt mask register bank.
 * Assumes it is included by its bare name from the design file; holds definitions only.
 */
`ifndef POWER_STATUS_REGS_DEFS_VH
`define POWER_STATUS_REGS_DEFS_VH

`define ADDR_W                8
`define DATA_W                8

`define OFS_TOP_INT_FLAGS     8'h20
`define OFS_TOP_LIVE_STATUS   8'h25
`define OFS_STEP_DOWN_STATUS  8'h26
`define OFS_STEP_UP_STATUS    8'h27
`define OFS_MONITOR_STATUS    8'h28
`define OFS_TOP_MASK_ONE      8'h29

`define BIT_SD2_ENABLED       7
`define BIT_SD2_VALID         6
`define BIT_SD2_ILIM          4
`define BIT_SD1_ENABLED       3
`define BIT_SD1_VALID         2
`define BIT_SD1_ILIM          0

`define BIT_SU_ENABLED        3
`define BIT_SU_VALID          2
`define BIT_SU_ILIM           0

`define BIT_MON_TWO_VALID     4
`define BIT_MON_ONE_VALID     2
`define BIT_ANALOG_VALID      0

`define BIT_LOAD_MEAS         7
`define BIT_SYNC_CLK          3
`define BIT_THERMAL_WARN      1

`define RST_STATUS            8'h00
`define RST_MASK              8'h00
`define RST_FLAGS             8'h00

`endif

// ### test/power_status_checker_assertions.sv
/* Port checker for the power status register bank.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/1ps
module power_status_checker
(
    input wire       ref_clk_in,
    input wire       nrst_in,
    input wire [7:0] reg_addr_in,
    input wire       reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire       reg_rvalid_out,
    input wire       first_stepdown_enabled_in
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    wire mapped = reg_addr_in == 8'h20 || (reg_addr_in >= 8'h25 && reg_addr_in <= 8'h29);
    sequence rd_at(a); reg_rd_in && reg_addr_in == a && !reg_wr_in; endsequence
    sequence mask_wr; reg_wr_in && reg_addr_in == 8'h29 && !reg_rd_in ##1 !reg_wr_in; endsequence
    chk_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    chk_no_spurious_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("valid without read");
    chk_unmapped_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_stepdown_reserved: assert property (rd_at(8'h26) |=> (reg_rdata_out & 8'h22) == 8'h00)
        else $error("step-down reserved bit set");
    chk_stepup_reserved: assert property (rd_at(8'h27) |=> (reg_rdata_out & 8'hF2) == 8'h00)
        else $error("step-up reserved bit set");
    chk_monitor_reserved: assert property (rd_at(8'h28) |=> (reg_rdata_out & 8'hEA) == 8'h00)
        else $error("monitor reserved bit set");
    chk_mask_readback: assert property (mask_wr ##1 rd_at(8'h29) |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("mask readback wrong");
    chk_live_enable: assert property ($stable(first_stepdown_enabled_in) [*3] ##0 rd_at(8'h26)
        |=> reg_rdata_out[3] == $past(first_stepdown_enabled_in)) else $error("enable bit wrong");
endmodule // power_status_checker
bind power_status_and_irq_mask_regs power_status_checker u_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .first_stepdown_enabled_in(first_stepdown_enabled_in));

// ### test/reg_host_model.sv
/* Host side of the decoded register port.
   Assumes one access at a time; read data answers one edge after the taking edge. */
`timescale 1ns/1ps
module reg_host_model
(
    input  wire       clk_in,
    input  wire [7:0] rdata_in,
    input  wire       rvalid_in,
    output reg  [7:0] addr_out = 8'h00,
    output reg        wr_out = 1'b0,
    output reg  [7:0] wdata_out = 8'h00,
    output reg        rd_out = 1'b0
);
    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
    end
    endtask
    task rd_reg(input [7:0] a, output [7:0] d);
    begin
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        // An unanswered read hands back unknowns, so the bench comparison trips
        d = rvalid_in ? rdata_in : 8'hXX;
    end
    endtask
endmodule // reg_host_model

// ### test/power_status_and_irq_mask_regs_tb.sv
/* Self-checking bench for the power status register bank.
   Assumes the host model drives the register port and the bench drives status and events. */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module power_status_and_irq_mask_regs_tb;
    reg         ref_clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg  [12:0] st = 13'h0000;
    reg         lm_ev = 1'b0;
    reg         sc_ev = 1'b0;
    reg  [7:0]  otp = 8'h00;
    wire [7:0]  addr, wdata, rdata;
    wire        wr, rd, irq, rvalid;
    reg  [7:0]  d, a;
    integer     seed = 32'hAF4D;
    integer     bad_count = 0;
    integer     comparisons = 0;
    integer     i, j, b;
    always #2.5 ref_clk_in = ~ref_clk_in;
    reg_host_model host (.clk_in(ref_clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
        .rd_out(rd), .rvalid_in(rvalid));
    power_status_and_irq_mask_regs dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .first_stepdown_enabled_in(st[0]), .first_stepdown_output_valid_in(st[1]),
        .first_stepdown_at_current_limit_in(st[2]), .second_stepdown_enabled_in(st[3]),
        .second_stepdown_output_valid_in(st[4]), .second_stepdown_at_current_limit_in(st[5]),
        .stepup_enabled_in(st[6]), .stepup_output_valid_in(st[7]), .stepup_at_current_limit_in(st[8]),
        .monitor_one_valid_in(st[9]), .monitor_two_valid_in(st[10]), .analog_supply_valid_in(st[11]),
        .thermal_warning_live_in(st[12]), .load_meas_ready_event_in(lm_ev), .sync_clk_event_in(sc_ev),
        .otp_mask_default_in(otp), .irq_out(irq));
    function [7:0] exp_rd(input [7:0] ad, input [12:0] s);
        case (ad)
            8'h26: exp_rd = {s[3], s[4], 1'b0, s[5], s[0], s[1], 1'b0, s[2]};
            8'h27: exp_rd = {4'h0, s[6], s[7], 1'b0, s[8]};
            8'h28: exp_rd = {3'h0, s[10], 1'b0, s[9], 1'b0, s[11]};
            8'h25: exp_rd = {6'h00, s[12], 1'b0};
            default: exp_rd = 8'h00;
        endcase
    endfunction
    task end_sim;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end
    endtask
    initial
    begin
        #20000;
        bad_count = bad_count + 1;
        end_sim;
    end
    initial
    begin
        otp <= $random(seed);
        repeat (2) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        host.rd_reg(8'h29, d);
        `CHK(d, otp)
        for (i = 0; i < 8; i = i + 1)
        begin
            // All-ones first, so every live bit is seen set at least once
            st <= (i == 0) ? 13'h1FFF : $random(seed);
            host.wr_reg(8'h26 + i % 3, 8'hFF);
            repeat (3) @(posedge ref_clk_in);
            for (j = 0; j < 5; j = j + 1)
            begin
                a = (j == 4) ? 8'h30 : 8'h25 + j;
                host.rd_reg(a, d);
                `CHK(d, exp_rd(a, st))
            end
        end
        st <= 13'h0000;
        repeat (3) @(posedge ref_clk_in);
        for (j = 0; j < 3; j = j + 1)
        begin
            b = (j == 0) ? 7 : (j == 1) ? 3 : 1;
            host.wr_reg(8'h29, 8'h01 << b);
            host.rd_reg(8'h29, d);
            `CHK(d, 8'h01 << b)
            host.wr_reg(8'h20, 8'hFF);
            lm_ev <= (b == 7);
            sc_ev <= (b == 3);
            st[12] <= (b == 1);
            @(posedge ref_clk_in);
            lm_ev <= 1'b0;
            sc_ev <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            `CHK(irq, 1'b0)
            host.rd_reg(8'h20, d);
            `CHK(d, 8'h01 << b)
            host.rd_reg(8'h25, d);
            `CHK(d[1], b == 1)
            host.wr_reg(8'h29, 8'h00);
            repeat (2) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            `CHK(irq, 1'b1)
            host.wr_reg(8'h20, 8'h01 << b);
            repeat (2) @(posedge ref_clk_in);
            @(negedge ref_clk_in);
            `CHK(irq, 1'b0)
        end
        // Mid-run reset: the mask must come back from the OTP default, not keep the last write
        st <= 13'h0000;
        host.wr_reg(8'h29, 8'h5A);
        nrst_in <= 1'b0;
        otp <= 8'hA5;
        repeat (2) @(posedge ref_clk_in);
        `CHK(irq, 1'b0)
        nrst_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        host.rd_reg(8'h29, d);
        `CHK(d, otp)
        host.rd_reg(8'h20, d);
        `CHK(d, 8'h00)
        end_sim;
    end
endmodule // power_status_and_irq_mask_regs_tb
